// ---- verilog/bit_test_branch_pkg.sv ----
// constants and types shared by the bit test and branch execution block
// Behaviour
// RL1: test_bit_skip_if_clear skips the next instruction when the chosen bit is zero.
// RL2: test_bit_skip_if_set skips the next instruction when the chosen bit is one.
// RL3: a taken skip drops the prefetched word and runs one empty cycle.
// RL4: skipping over a two-word instruction runs two empty cycles.
// RL5: operand bit a=0 uses access bank, a=1 uses bank_select_register bank.
// RL6: extended set, a=0 and address up to 95 uses indexed literal offset.
// RL7: toggle_bit inverts one bit, writes back in one cycle, flags untouched.
// RL8: taken flag branches load PC+2+2n and take two cycles, else one.
// RL9: watchdog_kick clears watchdog counter and postscaler, one cycle, no write.
// RL10: watchdog_kick sets timeout_flag and power_down_flag to one.
// RL11: invert_file_register complements, d picks accumulator or register, sets N and Z.
// RL12: compare_equal_skip compares without storing or flags, skips when equal.
// RL13: call pushes return address, loads 20-bit target, optional shadow copy.
// RL14: zero_file_register writes zero and sets the zero flag in one cycle.
package bit_test_branch_pkg;
   localparam int ADDR_W = 12;
   localparam int PC_W = 21;
   localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
   localparam logic [7:0] ACCESS_SFR_BASE = 8'h60;
   localparam logic [3:0] SFR_BANK = 4'hf;
   localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
   localparam logic [15:0] OP_WDT_KICK = 16'h0004;
   localparam logic [3:0] OP_TEST_CLR = 4'hb;
   localparam logic [3:0] OP_TEST_SET = 4'ha;
   localparam logic [3:0] OP_TOGGLE = 4'h7;
   localparam logic [7:0] OP_BR_OV = 8'he4;
   localparam logic [7:0] OP_BR_ZERO = 8'he0;
   localparam logic [6:0] OP_CALL = 7'h76;
   localparam logic [3:0] OP_SECOND = 4'hf;
   localparam logic [6:0] OP_ZERO_REG = 7'h35;
   localparam logic [5:0] OP_INVERT = 6'h07;
   localparam logic [6:0] OP_CMP_EQ = 7'h31;
   typedef enum logic [1:0] {EXEC, FLUSH, CALL2} exec_state_t;
endpackage

// ---- verilog/data_port_if.sv ----
// data memory address port between the executor and its address unit
`timescale 1ns/100ps
`default_nettype none
interface data_port_if;
   logic [7:0] fileAddr;
   logic accessBit;
   logic [11:0] physAddr;
   modport exec (output fileAddr, output accessBit, input physAddr);
   modport unit (input fileAddr, input accessBit, output physAddr);
endinterface
`default_nettype wire

// ---- verilog/bank_addr_unit.sv ----
// file address to data memory address mapping
`timescale 1ns/100ps
`default_nettype none
module bank_addr_unit
   import bit_test_branch_pkg::*;
(
   // address request
   data_port_if.unit port,
   // banking state
   input wire logic [3:0] bankSelect,
   input wire logic extendedSet,
   input wire logic [11:0] frameBase
);
   // access bank, indexed window or selected bank
   always_comb
   begin
      if (port.accessBit)
         port.physAddr = {bankSelect, port.fileAddr}; // see RL5
      else if (extendedSet && port.fileAddr <= ACCESS_LIMIT)
         port.physAddr = frameBase + {4'h0, port.fileAddr}; // see RL6
      else if (port.fileAddr >= ACCESS_SFR_BASE)
         port.physAddr = {SFR_BANK, port.fileAddr}; // see RL5
      else
         port.physAddr = {4'h0, port.fileAddr}; // see RL5
   end
endmodule
`default_nettype wire

// ---- verilog/bit_test_branch_exec.sv ----
// executor for bit test, branch, call, clear, complement and compare
`timescale 1ns/100ps
`default_nettype none
module bit_test_branch_exec
   import bit_test_branch_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // instruction stream
   input wire logic [15:0] instrWord,
   input wire logic instrValid,
   input wire logic nextIsTwoWord,
   input wire logic extendedSet,
   input wire logic [11:0] frameBase,
   // data memory
   output logic [11:0] memAddr,
   input wire logic [7:0] memRdata,
   output logic memWrite,
   output logic [7:0] memWdata,
   // core state
   output logic [PC_W-1:0] progCounter,
   output logic [7:0] accumulator,
   output logic [3:0] bankSelect,
   output logic zeroFlag,
   output logic negFlag,
   input wire logic overflowFlag,
   output logic timeoutFlag,
   output logic powerDownFlag,
   output logic [7:0] accumulatorShadow,
   output logic [7:0] flagsShadow,
   output logic [3:0] bankShadow,
   // return stack and watchdog
   output logic stackPush,
   output logic [PC_W-1:0] stackData,
   output logic watchdogClear,
   output logic busy
);
   import bit_test_branch_pkg::*;

   exec_state_t state;
   logic [1:0] flushLeft;
   logic [7:0] callLow;
   logic callShadow;
   // high while the flush stands for a skipped word, low after a jump
   logic flushAdvance;
   data_port_if port();

   bank_addr_unit addrUnit (
      .port(port),
      .bankSelect(bankSelect),
      .extendedSet(extendedSet),
      .frameBase(frameBase)
   );

   // decode strobes, valid only in the execute state
   logic go;
   logic isTestClr, isTestSet, isToggle, isBrOv, isBrZero, isCall;
   logic isZeroReg, isInvert, isCmpEq, isKick;
   logic [2:0] bitSel;
   logic bitVal, doSkip, doBranch;
   logic [7:0] inverted;
   assign go = instrValid && state == EXEC;
   assign isTestClr = go && instrWord[15:12] == OP_TEST_CLR;
   assign isTestSet = go && instrWord[15:12] == OP_TEST_SET;
   assign isToggle = go && instrWord[15:12] == OP_TOGGLE;
   assign isBrOv = go && instrWord[15:8] == OP_BR_OV;
   assign isBrZero = go && instrWord[15:8] == OP_BR_ZERO;
   assign isCall = go && instrWord[15:9] == OP_CALL;
   assign isZeroReg = go && instrWord[15:9] == OP_ZERO_REG;
   assign isInvert = go && instrWord[15:10] == OP_INVERT;
   assign isCmpEq = go && instrWord[15:9] == OP_CMP_EQ;
   assign isKick = go && instrWord == OP_WDT_KICK;
   assign bitSel = instrWord[11:9];
   assign bitVal = memRdata[bitSel];
   assign inverted = ~memRdata;
   // the skip decision needs the operand read this same cycle
   assign doSkip = (isTestClr && !bitVal) // see RL1
      || (isTestSet && bitVal) // see RL2
      || (isCmpEq && memRdata == accumulator); // see RL12
   assign doBranch = (isBrOv && overflowFlag) || (isBrZero && zeroFlag); // see RL8

   // operand address through the banking unit
   assign port.fileAddr = instrWord[7:0];
   assign port.accessBit = instrWord[8];
   assign memAddr = port.physAddr;

   // signed offset doubled and added past the branch word
   function automatic logic [PC_W-1:0] branchTarget(
      input logic [PC_W-1:0] pc, input logic [7:0] n);
      logic [PC_W-1:0] ext;
      ext = {{(PC_W-9){n[7]}}, n, 1'b0};
      branchTarget = pc + 21'h2 + ext;
   endfunction

   // write port: toggle, clear, complement to register
   always_comb
   begin
      memWrite = 1'b0;
      memWdata = 8'h00;
      if (isToggle)
      begin
         memWrite = 1'b1;
         memWdata = memRdata ^ (8'h01 << bitSel); // see RL7
      end
      else if (isZeroReg)
      begin
         memWrite = 1'b1; // see RL14
      end
      else if (isInvert && instrWord[9])
      begin
         memWrite = 1'b1;
         memWdata = inverted; // see RL11
      end
   end

   // sequencing: skip flushes and the call second word
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         state <= EXEC;
         flushLeft <= 2'h0;
         callLow <= 8'h00;
         callShadow <= 1'b0;
      end
      else
      begin
         unique case (state)
            EXEC:
               if (doSkip)
               begin
                  state <= FLUSH; // see RL3
                  flushLeft <= nextIsTwoWord ? 2'h1 : 2'h0; // see RL4
               end
               else if (doBranch)
               begin
                  state <= FLUSH; // see RL8
                  flushLeft <= 2'h0;
               end
               else if (isCall)
               begin
                  state <= CALL2;
                  callLow <= instrWord[7:0];
                  callShadow <= instrWord[8];
               end
            FLUSH:
               if (flushLeft == 2'h0)
                  state <= EXEC;
               else
                  flushLeft <= flushLeft - 2'h1; // see RL4
            CALL2:
               if (instrValid)
                  state <= FLUSH; // see RL13
         endcase
      end
   end
   assign busy = state != EXEC;

   // only a skip flush steps over a word; a jump target must not move
   always_ff @(posedge mclk)
   begin
      if (srst)
         flushAdvance <= 1'b0;
      else if (state == EXEC)
         flushAdvance <= doSkip; // see RL3
      else if (state == CALL2)
         flushAdvance <= 1'b0; // see RL13
   end

   // program counter
   always_ff @(posedge mclk)
   begin
      if (srst)
         progCounter <= PC_RESET;
      else if (doBranch)
         progCounter <= branchTarget(progCounter, instrWord[7:0]); // see RL8
      else if (state == CALL2 && instrValid)
         progCounter <= {instrWord[11:0], callLow, 1'b0}; // see RL13
      else if ((instrValid && state == EXEC) || (state == FLUSH && flushAdvance))
         progCounter <= progCounter + 21'h2; // see RL3 RL4
   end

   // return stack push, address of the word after the call
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         stackPush <= 1'b0;
         stackData <= PC_RESET;
      end
      else
      begin
         stackPush <= state == CALL2 && instrValid; // see RL13
         if (state == CALL2 && instrValid)
            stackData <= progCounter + 21'h2;
      end
   end

   // shadow copies on a fast call
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         accumulatorShadow <= 8'h00;
         flagsShadow <= 8'h00;
         bankShadow <= 4'h0;
      end
      else if (state == CALL2 && instrValid && callShadow)
      begin
         accumulatorShadow <= accumulator; // see RL13
         flagsShadow <= {3'h0, negFlag, overflowFlag, zeroFlag, 2'h0};
         bankShadow <= bankSelect;
      end
   end

   // accumulator and bank register; bank is only cleared by reset, nothing loads it
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         accumulator <= 8'h00;
         bankSelect <= 4'h0;
      end
      else if (isInvert && !instrWord[9])
         accumulator <= inverted; // see RL11
   end

   // arithmetic flags; compare and toggle leave them alone
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         zeroFlag <= 1'b0;
         negFlag <= 1'b0;
      end
      else if (isZeroReg)
         zeroFlag <= 1'b1; // see RL14
      else if (isInvert)
      begin
         zeroFlag <= inverted == 8'h00; // see RL11
         negFlag <= inverted[7];
      end
   end

   // watchdog kick and its status flags
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         watchdogClear <= 1'b0;
         timeoutFlag <= 1'b1;
         powerDownFlag <= 1'b1;
      end
      else
      begin
         watchdogClear <= isKick; // see RL9
         if (isKick)
         begin
            timeoutFlag <= 1'b1; // see RL10
            powerDownFlag <= 1'b1;
         end
      end
   end

   skip_one_a: assert property (@(posedge mclk) disable iff (srst)
      doSkip && !nextIsTwoWord |=> busy ##1 !busy)
      else $error("skip did not take one flush cycle"); // see RL3
   skip_two_a: assert property (@(posedge mclk) disable iff (srst)
      doSkip && nextIsTwoWord |=> busy [*2] ##1 !busy)
      else $error("two word skip length wrong"); // see RL4
   test_clr_a: assert property (@(posedge mclk) disable iff (srst)
      isTestClr && !memRdata[instrWord[11:9]] |=> busy)
      else $error("clear test did not skip"); // see RL1
   test_set_a: assert property (@(posedge mclk) disable iff (srst)
      isTestSet && !memRdata[instrWord[11:9]] |=> !busy)
      else $error("set test skipped on zero bit"); // see RL2
   cmp_eq_a: assert property (@(posedge mclk) disable iff (srst)
      isCmpEq |=> $stable(zeroFlag) && $stable(accumulator))
      else $error("compare changed state"); // see RL12
   branch_pc_a: assert property (@(posedge mclk) disable iff (srst)
      doBranch |=> progCounter == $past(progCounter) + 21'h2
         + {{12{$past(instrWord[7])}}, $past(instrWord[7:0]), 1'b0})
      else $error("branch target wrong"); // see RL8
   branch_hold_a: assert property (@(posedge mclk) disable iff (srst)
      doBranch |=> busy ##1 progCounter == $past(progCounter))
      else $error("branch target moved in flush"); // see RL8
   kick_flags_a: assert property (@(posedge mclk) disable iff (srst)
      isKick |=> watchdogClear && timeoutFlag && powerDownFlag && !$past(memWrite))
      else $error("watchdog kick effects missing"); // see RL9 RL10
   toggle_bit_a: assert property (@(posedge mclk) disable iff (srst)
      isToggle |-> memWrite && (memWdata ^ memRdata) == (8'h01 << bitSel))
      else $error("toggle wrote wrong value"); // see RL7
   zero_reg_a: assert property (@(posedge mclk) disable iff (srst)
      isZeroReg |-> memWrite && memWdata == 8'h00 ##1 zeroFlag)
      else $error("clear register effects missing"); // see RL14
   invert_acc_a: assert property (@(posedge mclk) disable iff (srst)
      isInvert && !instrWord[9] |=> accumulator == ~$past(memRdata))
      else $error("complement to accumulator wrong"); // see RL11
   call_push_a: assert property (@(posedge mclk) disable iff (srst)
      isCall ##1 instrValid |=> stackPush)
      else $error("call did not push"); // see RL13
   bank_sel_a: assert property (@(posedge mclk) disable iff (srst)
      instrWord[8] |-> memAddr == {bankSelect, instrWord[7:0]})
      else $error("banked address wrong"); // see RL5
   indexed_a: assert property (@(posedge mclk) disable iff (srst)
      !instrWord[8] && extendedSet && instrWord[7:0] <= ACCESS_LIMIT
         |-> memAddr == frameBase + {4'h0, instrWord[7:0]})
      else $error("indexed address wrong"); // see RL6
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the bit test and branch executor
`timescale 1ns/100ps
`default_nettype none
module tb;
   import bit_test_branch_pkg::*;
   localparam int PC_MASK = 32'h001fffff;
   // stimulus
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [15:0] instrWord = 16'h0000;
   logic instrValid = 1'b0;
   logic nextIsTwoWord = 1'b0;
   logic extendedSet = 1'b0;
   logic [11:0] frameBase = 12'h3a0;
   logic [7:0] memRdata = 8'h00;
   logic overflowFlag = 1'b0;
   // observed
   logic [11:0] memAddr;
   logic memWrite, zeroFlag, negFlag, timeoutFlag, powerDownFlag;
   logic stackPush, watchdogClear, busy;
   logic [7:0] memWdata, accumulator, accumulatorShadow, flagsShadow;
   logic [PC_W-1:0] progCounter, stackData;
   logic [3:0] bankSelect, bankShadow;
   // reference model
   int error_cnt = 0;
   int samples_checked = 0;
   int ePc, eAcc, eZ, eN, flushes;
   logic [7:0] seed = 8'h17;
   logic [7:0] rd, f;
   logic [19:0] k;

   bit_test_branch_exec DUT (
      .mclk, .srst, .instrWord, .instrValid, .nextIsTwoWord, .extendedSet,
      .frameBase, .memAddr, .memRdata, .memWrite, .memWdata, .progCounter,
      .accumulator, .bankSelect, .zeroFlag, .negFlag, .overflowFlag,
      .timeoutFlag, .powerDownFlag, .accumulatorShadow, .flagsShadow,
      .bankShadow, .stackPush, .stackData, .watchdogClear, .busy
   );

   always #5 mclk = ~mclk;

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // bank register has no writer, so banked accesses land in bank 0
   function automatic logic [11:0] addrOf(input logic a, input logic [7:0] x);
      if (a)
         return {4'h0, x};
      if (x > 8'h5f)
         return {4'hf, x};
      return extendedSet ? frameBase + {4'h0, x} : {4'h0, x};
   endfunction

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   // present one word at a falling edge, let the comb outputs settle
   task automatic issue(input logic [15:0] w, input logic [7:0] d);
      instrWord = w;
      memRdata = d;
      instrValid = 1'b1;
      #1;
   endtask

   // stale word and data are inverted so a late read cannot pass by luck
   task automatic step();
      @(negedge mclk);
      instrValid = 1'b0;
      instrWord = ~instrWord;
      memRdata = ~memRdata;
   endtask

   task automatic drain();
      flushes = 0;
      while (busy !== 1'b0)
      begin
         flushes++;
         if (flushes > 4)
         begin
            error_cnt++;
            $display("mismatch busy expected 0 seen 1");
            test_done();
         end
         @(negedge mclk);
      end
   endtask

   task automatic state();
      chk("pc", progCounter, ePc);
      chk("acc", accumulator, eAcc);
      chk("z", zeroFlag, eZ);
      chk("n", negFlag, eN);
   endtask

   task automatic resetDut();
      srst = 1'b1;
      repeat (8) @(negedge mclk);
      srst = 1'b0;
      ePc = 0;
      eAcc = 0;
      eZ = 0;
      eN = 0;
      state();
      chk("to", timeoutFlag, 1);
      chk("pd", powerDownFlag, 1);
   endtask

   // finish a skip-capable instruction: no write, count the empty cycles
   task automatic retire(input int t);
      chk("we", memWrite, 0);
      step();
      drain();
      chk("nops", flushes, t ? 1 + nextIsTwoWord : 0);
      ePc = ePc + 2 + (t ? 2 + 2 * nextIsTwoWord : 0);
      state();
   endtask

   // branches are checked at the load, then reset resyncs the model
   task automatic branch(input logic [7:0] op, input int t, input logic [7:0] n);
      int tgt;
      tgt = t ? (ePc + 2 + 2 * $signed(n)) & PC_MASK : ePc + 2;
      issue({op, n}, 8'h00);
      step();
      chk("pc", progCounter, tgt);
      drain();
      chk("nops", flushes, t);
      chk("pc", progCounter, tgt);
      resetDut();
   endtask

   initial
   begin
      resetDut();
      issue(OP_WDT_KICK, 8'h00);
      chk("we", memWrite, 0);
      step();
      chk("wdt", watchdogClear, 1);
      chk("to", timeoutFlag, 1);
      chk("pd", powerDownFlag, 1);
      ePc += 2;
      state();
      @(negedge mclk);
      chk("wdt", watchdogClear, 0);
      // bit tests over banks, the 5f/60 boundary and every bit
      for (int i = 0; i < 32; i++)
      begin
         seed = lfsr(seed);
         rd = lfsr(seed);
         f = i[3] ? 8'h5f : (i[4] ? 8'h60 : seed);
         extendedSet = seed[0];
         nextIsTwoWord = seed[7];
         issue({i[0] ? OP_TEST_SET : OP_TEST_CLR, i[2:0], seed[1], f}, rd);
         chk("addr", memAddr, addrOf(seed[1], f));
         retire(i[0] ? rd[i[2:0]] : !rd[i[2:0]]);
      end
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         issue({OP_TOGGLE, i[2:0], 1'b1, seed}, seed ^ 8'h5a);
         chk("we", memWrite, 1);
         chk("wd", memWdata, seed ^ 8'h5a ^ (8'h01 << i));
         step();
         ePc += 2;
         state();
      end
      // complement: all-ones, sign edge, zero and a value never all-ones
      for (int i = 0; i < 4; i++)
      begin
         rd = i == 0 ? 8'hff : i == 1 ? 8'h7f : i == 2 ? 8'h00 : seed & 8'hfe;
         issue({OP_INVERT, i[0], 1'b0, 8'h61}, rd);
         chk("we", memWrite, i[0]);
         chk("wd", memWrite ? memWdata : 8'h00, i[0] ? rd ^ 8'hff : 0);
         step();
         if (!i[0])
            eAcc = rd ^ 8'hff;
         eZ = rd == 8'hff;
         eN = !rd[7];
         ePc += 2;
         state();
      end
      for (int i = 0; i < 4; i++)
      begin
         nextIsTwoWord = i[1];
         issue({OP_CMP_EQ, 1'b0, 8'h20}, i[0] ? eAcc[7:0] : eAcc[7:0] ^ 8'h10);
         retire(i[0]);
      end
      issue({OP_ZERO_REG, 1'b0, 8'h10}, 8'h33);
      chk("addr", memAddr, addrOf(1'b0, 8'h10));
      chk("we", memWrite, 1);
      chk("wd", memWdata, 0);
      step();
      eZ = 1;
      ePc += 2;
      state();
      chk("busy", busy, 0);
      branch(OP_BR_ZERO, 1, 8'h80);
      branch(OP_BR_ZERO, 0, 8'h05);
      overflowFlag = 1'b1;
      branch(OP_BR_OV, 1, 8'h7f);
      overflowFlag = 1'b0;
      branch(OP_BR_OV, 0, 8'hf0);
      // call without, then with, the shadow copy
      for (int i = 0; i < 2; i++)
      begin
         overflowFlag = 1'b1;
         issue({OP_INVERT, 2'b00, 8'h61}, 8'h35);
         step();
         k = i ? 20'h12345 : 20'hfedcb;
         issue({OP_CALL, i[0], k[7:0]}, 8'h00);
         step();
         issue({OP_SECOND, k[19:8]}, 8'h00);
         step();
         chk("pc", progCounter, {k, 1'b0});
         chk("push", stackPush, 1);
         chk("ret", stackData, ePc + 6);
         chk("ws", accumulatorShadow, i ? 8'hca : 0);
         chk("fs", flagsShadow, i ? 8'h18 : 0);
         chk("bs", bankShadow, 0);
         @(negedge mclk);
         chk("push", stackPush, 0);
         drain();
         chk("pc", progCounter, {k, 1'b0});
         resetDut();
      end
      test_done();
   end
endmodule
`default_nettype wire
